// >>> shared/tone_readout_defines.vh
// Constants for the tone digit serial readout block.
`ifndef TONE_READOUT_DEFINES_VH
`define TONE_READOUT_DEFINES_VH
`define BIT_CNT_W        3
`define BIT_CNT_ZERO     3'h0
`define BIT_CNT_DONE     3'h4
`define BIT_CNT_STEP     3'h1
`define IDX_ZERO         4'h0
`define IDX_STAR         4'ha
`define IDX_HASH         4'hb
`define IDX_A            4'hc
`define IDX_B            4'hd
`define IDX_C            4'he
`define IDX_D            4'hf
`define CODE_ZERO        4'h0
`define KEY_D            4'h0
`define KEY_ZERO         4'ha
`define KEY_STAR         4'hb
`define KEY_HASH         4'hc
`define KEY_A            4'hd
`define KEY_B            4'he
`define KEY_C            4'hf
`define KEY_LAST_DECIMAL 4'h9
`endif

// >>> hdl/tone_digit_serial_readout.v
// Serial readout and power-down control of a received tone digit.
`timescale 1ns/1ns
// Overview of operation
// - Steering flag high while a valid digit held, outside power-down
// - First acknowledge edge latches code, shows LSB
// - Extra pulses ignored until steering rises again
// - Power-down entered on pin rise, acknowledge low
// - Acknowledge toggling in power-down is harmless
// - Power-down pin low returns normal operation
// - Held digit re-readable after power-down
// - n power-downs allow n plus one readouts
// - Key to four-bit code mapping
// - Code one drives high, zero drives low
// - Mode follows power-down and acknowledge levels
`include "tone_readout_defines.vh"
module tone_digit_serial_readout
(
  input  wire       clk,
  input  wire       srst,
  input  wire       digit_valid,
  input  wire [3:0] digit_key,
  input  wire       ack,
  input  wire       power_down_pin,
  output reg        early_steering_flag,
  output reg        serial_digit_out,
  output reg        power_down_mode
);

  // Key index: 0..9 digits, 10 star, 11 hash, 12..15 keys A..D.
  function [3:0] encode_key;
    input [3:0] key;
    begin
      case (key)
        `IDX_ZERO:
          encode_key = `KEY_ZERO;
        `IDX_STAR:
          encode_key = `KEY_STAR;
        `IDX_HASH:
          encode_key = `KEY_HASH;
        `IDX_A:
          encode_key = `KEY_A;
        `IDX_B:
          encode_key = `KEY_B;
        `IDX_C:
          encode_key = `KEY_C;
        `IDX_D:
          encode_key = `KEY_D;
        default:
          encode_key = key;
      endcase
    end
  endfunction

  // Bit that the pin shows next: the lowest bit of the code.
  function code_lsb;
    input [3:0] code;
    begin
      code_lsb = code[0];
    end
  endfunction

  // Code left after one bit has gone out, shifted down.
  function [3:0] code_rest;
    input [3:0] code;
    begin
      code_rest = {1'b0, code[3:1]};
    end
  endfunction

  // Synchroniser stages, edge history and readout state.
  reg                  ack_m_q;
  reg                  ack_s_q;
  reg                  ack_p_q;
  reg                  pd_m_q;
  reg                  pd_s_q;
  reg                  pd_p_q;
  reg                  val_m_q;
  reg                  val_s_q;
  reg [3:0]            key_m_q;
  reg [3:0]            key_s_q;
  reg [3:0]            shift_q;
  reg [3:0]            shift_d;
  reg [`BIT_CNT_W-1:0] cnt_q;
  reg [`BIT_CNT_W-1:0] cnt_d;
  reg                  mode_d;
  reg                  steer_d;
  reg                  sd_d;

  // Edges are taken from synchronised copies of the host pins.
  wire ack_rise;
  wire pd_rise;
  wire ready;
  wire rearm;
  wire first_bit;
  wire take;

  assign ack_rise  = ack_s_q & ~ack_p_q;
  assign pd_rise   = pd_s_q & ~pd_p_q;
  assign ready     = val_s_q & ~power_down_mode;
  // Steering rising again, fresh digit or back from power-down.
  assign rearm     = val_s_q & ~early_steering_flag & ready;
  assign first_bit = (cnt_q == `BIT_CNT_ZERO);
  // Pulses are refused in power-down, with the pin high, or after four.
  assign take      = ack_rise & ~power_down_mode & ~pd_s_q
                     & (cnt_q != `BIT_CNT_DONE);

  // Two-stage synchronisers; only the second stage is read by logic.
  always @(posedge clk)
  begin
    ack_m_q <= ack;
    ack_s_q <= ack_m_q;
    pd_m_q  <= power_down_pin;
    pd_s_q  <= pd_m_q;
    val_m_q <= digit_valid;
    val_s_q <= val_m_q;
    key_m_q <= digit_key;
    key_s_q <= key_m_q;
  end

  // Mode follows the level table; both pins high keeps the mode.
  always @*
  begin
    mode_d = power_down_mode;
    if (!pd_s_q)
      mode_d = 1'b0;
    else if (pd_rise && !ack_s_q)
      mode_d = 1'b1;
    else
      mode_d = power_down_mode;
  end

  // Steering reports a held digit only outside power-down.
  always @*
  begin
    steer_d = ready;
  end

  // Bit counter and shift register of the serial readout.
  // A fifth pulse finds the counter at four and is ignored.
  always @*
  begin
    cnt_d   = cnt_q;
    shift_d = shift_q;
    sd_d    = serial_digit_out;
    if (rearm)
    begin
      cnt_d = `BIT_CNT_ZERO;
    end
    else if (!val_s_q)
    begin
      cnt_d = `BIT_CNT_ZERO;
    end
    else if (take)
    begin
      if (first_bit)
      begin
        shift_d = code_rest(encode_key(key_s_q));
        sd_d    = code_lsb(encode_key(key_s_q));
      end
      else
      begin
        shift_d = code_rest(shift_q);
        sd_d    = code_lsb(shift_q);
      end
      cnt_d = cnt_q + `BIT_CNT_STEP;
    end
  end

  // Previous synchronised levels, for edge detection.
  always @(posedge clk)
  begin
    if (srst)
    begin
      ack_p_q <= 1'b0;
      pd_p_q  <= 1'b0;
    end
    else
    begin
      ack_p_q <= ack_s_q;
      pd_p_q  <= pd_s_q;
    end
  end

  // Mode and steering outputs.
  always @(posedge clk)
  begin
    if (srst)
    begin
      power_down_mode     <= 1'b0;
      early_steering_flag <= 1'b0;
    end
    else
    begin
      power_down_mode     <= mode_d;
      early_steering_flag <= steer_d;
    end
  end

  // Readout state and the serial output pin.
  always @(posedge clk)
  begin
    if (srst)
    begin
      serial_digit_out <= 1'b0;
      shift_q          <= `CODE_ZERO;
      cnt_q            <= `BIT_CNT_ZERO;
    end
    else
    begin
      serial_digit_out <= sd_d;
      shift_q          <= shift_d;
      cnt_q            <= cnt_d;
    end
  end

endmodule

// >>> bench/tone_chk_checker.sv
// Pin checks on the readout block.
`timescale 1ns/1ns
module tone_chk(input wire clk, srst, digit_valid, ack, power_down_pin,
  early_steering_flag, serial_digit_out, power_down_mode,
  input wire [3:0] digit_key);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  chk_pd_quiet: assert property (
    power_down_mode && $past(power_down_mode) |-> !early_steering_flag)
    else $error("pd steer");
  chk_pd_enter: assert property (
    (!ack && power_down_pin && !$past(power_down_pin)) ##1
    (!ack && power_down_pin) [*3] |=> power_down_mode)
    else $error("pd not entered");
  chk_steer_drop: assert property (
    !digit_valid [*4] |-> !early_steering_flag) else $error("steer");
  chk_pd_hold: assert property (
    (power_down_mode && power_down_pin) [*6] |=> power_down_mode)
    else $error("pd lost");
  chk_pd_exit: assert property (
    !power_down_pin [*6] |-> !power_down_mode) else $error("pd stuck");
  chk_sd_hold: assert property (
    (!ack && digit_valid) [*6] |=> $stable(serial_digit_out))
    else $error("sd moved");
endmodule
bind tone_digit_serial_readout tone_chk chk(.*);

// >>> bench/host_model.sv
// Host driving acknowledge and power-down pins.
`timescale 1ns/1ns
module host_model(input wire clk, input wire serial_digit_out,
  input wire power_down_mode,
  output reg ack = 1'b0, output reg power_down_pin = 1'b0);
  // One pulse at the link rate; the bit is taken as ack falls.
  task pulse(output reg b);
    begin
      repeat (8) @(posedge clk);
      ack <= 1'b1;
      repeat (8) @(posedge clk);
      b = serial_digit_out;
      ack <= 1'b0;
    end
  endtask
  task read4(output reg [3:0] c);
    integer i;
    for (i = 0; i < 4; i = i + 1) pulse(c[i]);
  endtask
  task nap(output reg m, output reg s);
    begin
      power_down_pin <= 1'b1;
      pulse(s);
      m = power_down_mode;
      power_down_pin <= 1'b0;
    end
  endtask
endmodule

// >>> bench/tb.sv
// Bench for the tone digit readout.
`timescale 1ns/1ns
module tb;
  reg clk = 1'b0, srst = 1'b1, digit_valid = 1'b0, b, pd;
  reg [3:0] digit_key = 4'h0, got;
  wire ack, power_down_pin, early_steering_flag, serial_digit_out,
    power_down_mode;
  integer fail_count = 0, n_compared = 0, j, t;
  tone_digit_serial_readout dut(.*);
  host_model h(.*);
  initial forever #4 clk = ~clk;
  task check(input [3:0] g, e);
    begin
      n_compared = n_compared + 1;
      if (g !== e) fail_count = fail_count + 1;
      if (g !== e) $display("[ERR] %0t got %h want %h", $time, g, e);
    end
  endtask
  task report_and_stop;
    begin
      $display("fails %0d of %0d", fail_count, n_compared);
      if (fail_count == 0 && n_compared > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
    end
  endtask
  function [3:0] code(input [3:0] i);
    code = i == 4'h0 ? 4'ha : i == 4'hf ? 4'h0 : i > 4'h9 ? i + 4'h1 : i;
  endfunction
  task read_key(input [3:0] i);
    begin
      digit_key <= i;
      digit_valid <= 1'b1;
      for (t = 0; t < 40 && early_steering_flag !== 1'b1; t = t + 1)
        @(posedge clk);
      check({3'h0, early_steering_flag}, 4'h1);
      if (t == 40) report_and_stop;
      h.read4(got);
      check(got, code(i));
    end
  endtask
  task t_codes;
    for (j = 0; j < 16; j = j + 1)
    begin
      read_key(j[3:0]);
      h.pulse(b);
      check({3'h0, b}, code(j[3:0]) >> 3);
      digit_valid <= 1'b0;
      repeat (8) @(posedge clk);
    end
  endtask
  task t_reread;
    begin
      read_key(4'hd);
      h.nap(pd, b);
      check({3'h0, pd}, 4'h1);
      check({3'h0, b}, code(4'hd) >> 3);
      read_key(4'hd);
      check({3'h0, power_down_mode}, 4'h0);
      h.nap(pd, b);
      check({3'h0, pd}, 4'h1);
      read_key(4'hd);
    end
  endtask
  initial
  begin
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    h.read4(got);
    t_codes;
    t_reread;
    report_and_stop;
  end
endmodule
